/* sas_pkg.sv */
package sas_pkg;
   // clock of the whole block and the lowest cpu clock the prescaler serves
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned MIN_CPU_HZ = 100_000;

   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] SEL_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;
   localparam logic [11:0] RES_OFS = 12'h00c;

   // control_status_a field positions
   localparam int unsigned ON_BIT = 0;
   localparam int unsigned START_BIT = 1;
   localparam int unsigned AUTO_BIT = 2;
   localparam int unsigned DONE_BIT = 3;
   localparam int unsigned DIV_LSB = 4;
   localparam int unsigned FREE_BIT = 7;
   localparam int unsigned DIFF_BIT = 8;

   // input_select_reg field positions
   localparam int unsigned CHAN_LSB = 0;
   localparam int unsigned REF_LSB = 6;

   // field widths
   localparam int unsigned DIV_W = 3;
   localparam int unsigned CHAN_W = 5;
   localparam int unsigned REF_W = 2;
   localparam int unsigned RES_W = 10;
   localparam int unsigned HALF_W = 6;

   // reset values
   localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
   localparam logic [REF_W-1:0] REF_RST = 2'h0;

   // conversion timing, counted in converter half cycles
   localparam logic [HALF_W-1:0] NORM_SH_HALF = 6'h03;    // 1.5 cycles
   localparam logic [HALF_W-1:0] NORM_DONE_HALF = 6'h1a;  // 13 cycles
   localparam logic [HALF_W-1:0] FIRST_SH_HALF = 6'h1b;   // 13.5 cycles
   localparam logic [HALF_W-1:0] FIRST_DONE_HALF = 6'h32; // 25 cycles
   localparam logic [HALF_W-1:0] AUTO_SH_HALF = 6'h04;    // 2 cycles
   localparam logic [HALF_W-1:0] AUTO_DONE_HALF = 6'h1b;  // 13.5 cycles
   localparam logic [HALF_W-1:0] DIFF_SYNC_HALF = 6'h02;  // one extra cycle
   localparam logic [HALF_W-1:0] LAST_CYC_HALF = 6'h02;   // final converter cycle

   // trigger synchroniser depth in cpu cycles
   localparam int unsigned TRIG_SYNC_CYC = 3;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} sas_state_t;
endpackage

/* sas_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_prescaler
   import sas_pkg::*;
#(
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic clr,
   input wire logic [DIV_W-1:0] div_sel,
   // converter clock edges as enables
   output logic conv_rise,
   output logic conv_fall
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] top;

   // power-of-two ratio, codes 0 and 1 both divide by two
   function automatic logic [CNT_W-1:0] ratio_top(input logic [DIV_W-1:0] sel);
      logic [CNT_W:0] r;
      r = (sel == 3'h0) ? (CNT_W+1)'(2) : (CNT_W+1)'(1) << sel;
      return CNT_W'(r - (CNT_W+1)'(1));
   endfunction

   assign top = ratio_top(div_sel);

   // held in reset while converter is off or a trigger restarts it
   always_comb begin
      if (!run || clr) begin
         cnt_next = '0;
      end else if (cnt_reg == top) begin
         cnt_next = '0;
      end else begin
         cnt_next = cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // rising edge at wrap, falling edge half way through the period
   assign conv_rise = run && !clr && (cnt_reg == top);
   assign conv_fall = run && !clr && (cnt_reg == (top >> 1));
endmodule
`default_nettype wire

/* sas_trig_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_trig_sync
   import sas_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous trigger and its rising edge
   input wire logic trig_in,
   output logic trig_rise
);
   logic [TRIG_SYNC_CYC-1:0] sh_reg;
   logic [TRIG_SYNC_CYC-1:0] sh_next;

   // two flops for metastability, third only for edge detection
   always_comb begin
      sh_next = {sh_reg[TRIG_SYNC_CYC-2:0], trig_in};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= '0;
      end else begin
         sh_reg <= sh_next;
      end
   end

   assign trig_rise = sh_reg[1] && !sh_reg[2];
endmodule
`default_nettype wire

/* sas_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
   import sas_pkg::*;
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter side
   input wire logic trig_in,
   input wire logic [RES_W-1:0] conv_result_in,
   output logic sample_hold,
   output logic conv_done,
   output logic conv_busy,
   output logic conv_tick,
   output logic half_rate_conv_clock,
   output logic [CHAN_W-1:0] working_channel,
   output logic [REF_W-1:0] working_ref
);
   // control and state registers
   sas_state_t state_reg, state_next;
   logic on_reg, on_next;
   logic auto_reg, auto_next;
   logic free_reg, free_next;
   logic diff_reg, diff_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic start_reg, start_next;
   logic done_reg, done_next;
   logic first_reg, first_next;
   logic hr_reg, hr_next;
   logic [HALF_W-1:0] cnt_reg, cnt_next;
   logic [HALF_W-1:0] sh_tgt_reg, sh_tgt_next;
   logic [HALF_W-1:0] done_tgt_reg, done_tgt_next;
   logic [CHAN_W-1:0] chan_tmp_reg, chan_tmp_next;
   logic [REF_W-1:0] ref_tmp_reg, ref_tmp_next;
   logic [CHAN_W-1:0] chan_reg, chan_next;
   logic [REF_W-1:0] ref_reg, ref_next;
   logic [RES_W-1:0] res_reg, res_next;
   logic sh_reg, sh_next;
   logic cdone_reg, cdone_next;
   logic tick_reg, tick_next;
   // bus registers
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   // internal wires
   logic conv_rise, conv_fall, trig_rise, trig_fire, lock;
   logic wr_ctrl, wr_sel, acc;
   logic [HALF_W-1:0] cnt_inc;

   // register index from byte address, 3'h4 means unmapped
   function automatic logic [2:0] reg_idx(input logic [11:0] a);
      if (a == CTRL_OFS) begin
         return 3'h0;
      end else if (a == SEL_OFS) begin
         return 3'h1;
      end else if (a == STAT_OFS) begin
         return 3'h2;
      end else if (a == RES_OFS) begin
         return 3'h3;
      end else begin
         return 3'h4;
      end
   endfunction

   sas_prescaler #(.CNT_W(8)) u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .run(on_reg),
      .clr(trig_fire),
      .div_sel(div_reg),
      .conv_rise(conv_rise),
      .conv_fall(conv_fall)
   );

   sas_trig_sync u_trig (
      .pclk(pclk),
      .presetn(presetn),
      .trig_in(trig_in),
      .trig_rise(trig_rise)
   );

   // bus access strobes; pready comes one cycle into the access phase
   assign acc = psel && penable && pready_reg;
   assign wr_ctrl = acc && pwrite && (reg_idx(paddr) == 3'h0);
   assign wr_sel = acc && pwrite && (reg_idx(paddr) == 3'h1);

   // external trigger only when idle; free running uses completion instead
   assign trig_fire = on_reg && auto_reg && !free_reg && trig_rise &&
      (state_reg == ST_IDLE);

   // locked from start until the last converter cycle
   assign lock = (state_reg == ST_CONV) &&
      (cnt_reg < (done_tgt_reg - LAST_CYC_HALF));
   assign cnt_inc = cnt_reg + HALF_W'(1);

   // conversion sequencer
   always_comb begin
      state_next = state_reg;
      start_next = start_reg;
      done_next = done_reg;
      first_next = first_reg;
      hr_next = hr_reg;
      cnt_next = cnt_reg;
      sh_tgt_next = sh_tgt_reg;
      done_tgt_next = done_tgt_reg;
      res_next = res_reg;
      sh_next = 1'b0;
      cdone_next = 1'b0;
      tick_next = conv_rise;
      // half-rate clock restarts with the prescaler
      if (trig_fire) begin
         hr_next = 1'b0;
      end else if (conv_rise) begin
         hr_next = !hr_reg;
      end
      case (state_reg)
         ST_IDLE: begin
            if (trig_fire) begin
               state_next = ST_CONV;
               cnt_next = '0;
               first_next = 1'b0;
               if (first_reg || diff_reg) begin
                  sh_tgt_next = FIRST_SH_HALF;
                  done_tgt_next = FIRST_DONE_HALF;
               end else begin
                  sh_tgt_next = AUTO_SH_HALF;
                  done_tgt_next = AUTO_DONE_HALF;
               end
            end else if (start_reg) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (conv_rise) begin
               state_next = ST_CONV;
               cnt_next = '0;
               first_next = 1'b0;
               if (first_reg) begin
                  sh_tgt_next = FIRST_SH_HALF;
                  done_tgt_next = FIRST_DONE_HALF;
               end else if (diff_reg && hr_reg) begin
                  sh_tgt_next = NORM_SH_HALF + DIFF_SYNC_HALF;
                  done_tgt_next = NORM_DONE_HALF + DIFF_SYNC_HALF;
               end else begin
                  sh_tgt_next = NORM_SH_HALF;
                  done_tgt_next = NORM_DONE_HALF;
               end
            end
         end
         ST_CONV: begin
            if (conv_rise || conv_fall) begin
               cnt_next = cnt_inc;
               if (cnt_inc == sh_tgt_reg) begin
                  sh_next = 1'b1;
               end
               if (cnt_inc == done_tgt_reg) begin
                  res_next = conv_result_in;
                  done_next = 1'b1;
                  cdone_next = 1'b1;
                  if (auto_reg && free_reg) begin
                     cnt_next = '0;
                     sh_tgt_next = NORM_SH_HALF + (diff_reg ? DIFF_SYNC_HALF : '0);
                     done_tgt_next = NORM_DONE_HALF + (diff_reg ? DIFF_SYNC_HALF : '0);
                  end else begin
                     state_next = ST_IDLE;
                     start_next = 1'b0;
                  end
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // software clears the flag by writing one; a same-cycle set wins
      if (wr_ctrl && pwdata[DONE_BIT] && !cdone_next) begin
         done_next = 1'b0;
      end
      // writing zero to start has no effect; writing one together with on wins over a clear
      if (wr_ctrl && pwdata[START_BIT] && pwdata[ON_BIT]) begin
         start_next = 1'b1;
      end
      // switching on schedules the extended conversion
      if (wr_ctrl && pwdata[ON_BIT] && !on_reg) begin
         first_next = 1'b1;
      end
      // switching off aborts everything
      if (!on_reg) begin
         state_next = ST_IDLE;
         start_next = start_next && wr_ctrl && pwdata[ON_BIT];
         cnt_next = '0;
         hr_next = 1'b0;
         sh_next = 1'b0;
         cdone_next = 1'b0;
      end
   end

   // control bits and selection buffering
   always_comb begin
      on_next = on_reg;
      auto_next = auto_reg;
      free_next = free_reg;
      diff_next = diff_reg;
      div_next = div_reg;
      chan_tmp_next = chan_tmp_reg;
      ref_tmp_next = ref_tmp_reg;
      chan_next = chan_reg;
      ref_next = ref_reg;
      if (wr_ctrl) begin
         on_next = pwdata[ON_BIT];
         auto_next = pwdata[AUTO_BIT];
         free_next = pwdata[FREE_BIT];
         diff_next = pwdata[DIFF_BIT];
         div_next = pwdata[DIV_LSB +: DIV_W];
      end
      if (wr_sel) begin
         chan_tmp_next = pwdata[CHAN_LSB +: CHAN_W];
         ref_tmp_next = pwdata[REF_LSB +: REF_W];
      end
      // working selection only moves while enabled and unlocked
      if (on_reg && !lock) begin
         chan_next = chan_tmp_reg;
         ref_next = ref_tmp_reg;
      end
   end

   // apb answer: one wait state, data captured with pready
   always_comb begin
      pready_next = psel && penable && !pready_reg;
      pslverr_next = 1'b0;
      prdata_next = '0;
      if (pready_next) begin
         if (reg_idx(paddr) == 3'h0) begin
            prdata_next[ON_BIT] = on_reg;
            prdata_next[START_BIT] = start_reg || (state_reg != ST_IDLE);
            prdata_next[AUTO_BIT] = auto_reg;
            prdata_next[DONE_BIT] = done_reg;
            prdata_next[DIV_LSB +: DIV_W] = div_reg;
            prdata_next[FREE_BIT] = free_reg;
            prdata_next[DIFF_BIT] = diff_reg;
         end else if (reg_idx(paddr) == 3'h1) begin
            prdata_next[CHAN_LSB +: CHAN_W] = chan_tmp_reg;
            prdata_next[REF_LSB +: REF_W] = ref_tmp_reg;
         end else if (reg_idx(paddr) == 3'h2) begin
            prdata_next[CHAN_LSB +: CHAN_W] = chan_reg;
            prdata_next[REF_LSB +: REF_W] = ref_reg;
            prdata_next[8] = (state_reg == ST_CONV);
            prdata_next[9] = lock;
            prdata_next[10] = hr_reg;
            prdata_next[11] = first_reg;
         end else if (reg_idx(paddr) == 3'h3) begin
            prdata_next[RES_W-1:0] = res_reg;
         end else begin
            pslverr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         on_reg <= 1'b0;
         auto_reg <= 1'b0;
         free_reg <= 1'b0;
         diff_reg <= 1'b0;
         div_reg <= DIV_RST;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         first_reg <= 1'b1;
         hr_reg <= 1'b0;
         cnt_reg <= '0;
         sh_tgt_reg <= NORM_SH_HALF;
         done_tgt_reg <= NORM_DONE_HALF;
         chan_tmp_reg <= CHAN_RST;
         ref_tmp_reg <= REF_RST;
         chan_reg <= CHAN_RST;
         ref_reg <= REF_RST;
         res_reg <= '0;
         sh_reg <= 1'b0;
         cdone_reg <= 1'b0;
         tick_reg <= 1'b0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         on_reg <= on_next;
         auto_reg <= auto_next;
         free_reg <= free_next;
         diff_reg <= diff_next;
         div_reg <= div_next;
         start_reg <= start_next;
         done_reg <= done_next;
         first_reg <= first_next;
         hr_reg <= hr_next;
         cnt_reg <= cnt_next;
         sh_tgt_reg <= sh_tgt_next;
         done_tgt_reg <= done_tgt_next;
         chan_tmp_reg <= chan_tmp_next;
         ref_tmp_reg <= ref_tmp_next;
         chan_reg <= chan_next;
         ref_reg <= ref_next;
         res_reg <= res_next;
         sh_reg <= sh_next;
         cdone_reg <= cdone_next;
         tick_reg <= tick_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // outputs straight from flops, except conv_busy decoded from state_reg
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sample_hold = sh_reg;
   assign conv_done = cdone_reg;
   assign conv_busy = (state_reg == ST_CONV);
   assign conv_tick = tick_reg;
   assign half_rate_conv_clock = hr_reg;
   assign working_channel = chan_reg;
   assign working_ref = ref_reg;
endmodule
`default_nettype wire

/* sas_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sas_checker
   import sas_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus answer
   input wire logic pready,
   input wire logic pslverr,
   // converter side
   input wire logic sample_hold,
   input wire logic conv_done,
   input wire logic conv_busy,
   input wire logic conv_tick,
   input wire logic half_rate_conv_clock,
   input wire logic [CHAN_W-1:0] working_channel,
   input wire logic [REF_W-1:0] working_ref
);
   logic [7:0] tick_reg, tick_next;
   logic [7:0] gap_reg, gap_next;
   logic seen_reg, seen_next;

   // converter ticks since hold, cycles since completion; gap saturates so idle spells stay safe
   always_comb begin
      tick_next = sample_hold ? 8'h00 : tick_reg + {7'h00, conv_tick};
      gap_next = conv_done ? 8'h00 : ((gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h01);
      seen_next = seen_reg | conv_done;
   end

   // helper state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= 8'h00;
         gap_reg <= 8'h00;
         seen_reg <= 1'b0;
      end else begin
         tick_reg <= tick_next;
         gap_reg <= gap_next;
         seen_reg <= seen_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_tick_gap: assert property (conv_tick |=> !conv_tick)
      else $error("converter ticks on adjacent cycles");
   chk_half_rate: assert property ($changed(half_rate_conv_clock) |=> $stable(half_rate_conv_clock))
      else $error("half rate clock toggles too fast");
   chk_hold_busy: assert property (sample_hold |-> conv_busy)
      else $error("hold outside a conversion");
   chk_hold_once: assert property (sample_hold |=> (!sample_hold) [*8])
      else $error("second hold too soon");
   chk_hold_lock: assert property (sample_hold |=> ($stable(working_channel) && $stable(working_ref)) [*8])
      else $error("selection moved during conversion");
   chk_done_busy: assert property (conv_done |-> $past(conv_busy, 3))
      else $error("completion without a running conversion");
   chk_hold_done: assert property (conv_done |-> tick_reg inside {[8'd11:8'd12]})
      else $error("hold to completion not 11.5 converter cycles");
   chk_done_gap: assert property (conv_done && seen_reg |-> gap_reg >= 8'd25)
      else $error("completions closer than 13 converter cycles");
endmodule

bind sas_sequencer sas_checker u_chk (.pclk(pclk), .presetn(presetn), .pready(pready),
   .pslverr(pslverr), .sample_hold(sample_hold), .conv_done(conv_done), .conv_busy(conv_busy),
   .conv_tick(conv_tick), .half_rate_conv_clock(half_rate_conv_clock),
   .working_channel(working_channel), .working_ref(working_ref));
`default_nettype wire

/* sas_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sas_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic trig_in = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [RES_W-1:0] conv_result_in = 10'h000;
   logic [31:0] prdata;
   logic pready, pslverr, sample_hold, conv_done, conv_busy, conv_tick, half_rate_conv_clock;
   logic [CHAN_W-1:0] working_channel;
   logic [REF_W-1:0] working_ref;
   int mismatches = 0, checks_done = 0;
   int hold_age = 0, done_age = 0, gap_hd = 0;

   always #4 pclk = ~pclk;

   sas_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_in(trig_in), .conv_result_in(conv_result_in),
      .sample_hold(sample_hold), .conv_done(conv_done), .conv_busy(conv_busy),
      .conv_tick(conv_tick), .half_rate_conv_clock(half_rate_conv_clock),
      .working_channel(working_channel), .working_ref(working_ref));

   // distance from hold to completion, in pclk cycles
   always @(posedge pclk) begin
      hold_age <= (sample_hold === 1'b1) ? 0 : hold_age + 1;
      if (conv_done === 1'b1) gap_hd <= hold_age + 1;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rng(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   // one apb transfer, entered just after a rising edge; one idle edge after release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      if (n >= 50) rng(n, 0, 49);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // wait for completion (0), hold (1) or converter tick (2), bounded
   task automatic wait_ev(input int which, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!((which == 0) ? conv_done === 1'b1 :
                   (which == 1) ? sample_hold === 1'b1 : conv_tick === 1'b1) && n < 3000);
      if (n >= 3000) rng(n, 0, 2999);
   endtask

   // count converter ticks over a quiet spell
   task automatic quiet_ticks(output int t);
      t = 0;
      repeat (40) begin
         @(posedge pclk);
         if (conv_tick === 1'b1) t++;
      end
   endtask

   task automatic t_reset;
      logic [31:0] q;
      logic e;
      int t;
      rd(CTRL_OFS, q); cmp(q, 32'h0);
      rd(SEL_OFS, q); cmp(q, 32'h0);
      rd(STAT_OFS, q); cmp(q, 32'h800);
      rd(RES_OFS, q); cmp(q, 32'h0);
      apb(1'b0, 12'h010, 32'h0, q, e);
      cmp({31'h0, e}, 32'h1);
      cmp(q, 32'h0);
      quiet_ticks(t); rng(t, 0, 0);
   endtask

   task automatic t_first;
      logic [31:0] q;
      int n;
      wr(SEL_OFS, 32'h05);
      wr(CTRL_OFS, 32'h001);
      @(posedge pclk);
      cmp(working_channel, 32'h5);
      conv_result_in <= 10'h2a5;
      wr(CTRL_OFS, 32'h003);
      wait_ev(0, n); rng(n, 46, 54);
      rd(CTRL_OFS, q); cmp(q, 32'h009);
      rng(gap_hd, 22, 24);
      rd(RES_OFS, q); cmp(q, 32'h2a5);
      rd(STAT_OFS, q); cmp(q & 32'h900, 32'h0);
   endtask

   task automatic t_normal;
      logic [31:0] q;
      int n;
      wr(CTRL_OFS, 32'h00b);
      wait_ev(1, n); rng(n, 1, 6);
      wr(SEL_OFS, 32'h43);
      cmp(working_channel, 32'h5);
      wait_ev(0, n); rng(n, 14, 20);
      rd(CTRL_OFS, q); cmp(q, 32'h009);
      cmp(working_channel, 32'h3);
      cmp(working_ref, 32'h1);
      rng(gap_hd, 22, 24);
      wr(CTRL_OFS, 32'h009);
      rd(CTRL_OFS, q); cmp(q, 32'h001);
   endtask

   // every divide select, exact spacing of converter ticks
   task automatic t_div;
      int n;
      for (int d = 0; d < 8; d++) begin
         wr(CTRL_OFS, 32'h1 | (32'(d) << DIV_LSB));
         wait_ev(2, n);
         wait_ev(2, n); rng(n, (d < 2) ? 2 : (1 << d), (d < 2) ? 2 : (1 << d));
      end
      wr(CTRL_OFS, 32'h001);
   endtask

   task automatic t_trig;
      int n, c;
      wr(CTRL_OFS, 32'h005);
      trig_in <= 1'b1;
      wait_ev(1, n); rng(n, 5, 10);
      trig_in <= 1'b0;
      repeat (3) @(posedge pclk);
      trig_in <= 1'b1;
      wait_ev(0, n);
      c = 0;
      repeat (60) begin
         @(posedge pclk);
         if (conv_busy === 1'b1) c++;
      end
      rng(c, 0, 0);
      rng(gap_hd, 22, 24);
      trig_in <= 1'b0;
      wr(CTRL_OFS, 32'h009);
      // differential triggered: converter cycled off and on first
      wr(CTRL_OFS, 32'h000);
      wr(CTRL_OFS, 32'h105);
      trig_in <= 1'b1;
      wait_ev(0, n); rng(n, 52, 56);
      rng(gap_hd, 22, 24);
      trig_in <= 1'b0;
      wr(CTRL_OFS, 32'h009);
   endtask

   task automatic t_free;
      logic [31:0] q;
      int n, t;
      // settling-spell results of the new differential pair are discarded
      wr(CTRL_OFS, 32'h187);
      wait_ev(0, n);
      wait_ev(0, n); rng(n, 28, 28);
      wr(SEL_OFS, 32'h47);
      cmp(working_channel, 32'h3);
      rd(CTRL_OFS, q); cmp({31'h0, q[START_BIT]}, 32'h1);
      wait_ev(0, n); rng(n, 1, 28);
      cmp(working_channel, 32'h7);
      wr(CTRL_OFS, 32'h000);
      quiet_ticks(t); rng(t, 0, 0);
      wr(CTRL_OFS, 32'h001);
      rd(STAT_OFS, q); cmp({31'h0, q[11]}, 32'h1);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // main sequence after a 16 cycle reset
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_first;
      t_normal;
      t_div;
      t_trig;
      t_free;
      end_of_test;
   end

   // the whole run needs well under half this span
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
`default_nettype wire
